// File: dsw_assertions.sv
/*
  Checker on the DAC two-wire slave top ports, bound to dsw_top.
  Assumes SDA_IN carries the resolved wire level.
*/
`timescale 1ns/1ps
`include "dsw_map.svh"
module dsw_assertions (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic SCL,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  input wire logic [`DSW_CODE_WIDTH-1:0] DAC_CODE,
  input wire logic DAC_SHUTDOWN,
  input wire logic INTERNAL_REF_SELECT,
  input wire logic SYNC_UPDATE_MODE
);
  logic scl_q, sda_q;
  logic [3:0] bits_q;
  default clocking dc @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // Clock rises since START, wrapping to zero on the acknowledge clock rise
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bits_q <= 4'h0;
    end else begin
      scl_q <= SCL;
      sda_q <= SDA_IN;
      if (SCL && scl_q && sda_q && !SDA_IN) bits_q <= 4'h0;
      else if (SCL && !scl_q) bits_q <= (bits_q == 4'h8) ? 4'h0 : bits_q + 4'h1;
    end
  end
  AST_OUT_LOW: assert property (SDA_OUT == 1'b0)
    else $error("data output not low");
  AST_DRIVE_LOW: assert property ($fell(SDA_OE_N) |-> !SCL)
    else $error("pull started with clock high");
  AST_ACK_AT_NINE: assert property ($fell(SDA_OE_N) |-> bits_q == 4'h8)
    else $error("pull not after eighth bit");
  AST_ACK_HOLD: assert property (SCL && !SDA_OE_N |=> !SDA_OE_N || !SCL)
    else $error("pull released with clock high");
  AST_ACK_ENDS: assert property ($fell(SDA_OE_N) |-> ##[1:200] SDA_OE_N)
    else $error("pull never released");
  AST_CODE_HI: assert property (!$stable({DAC_CODE, INTERNAL_REF_SELECT}) |-> SCL)
    else $error("code moved with clock low");
  AST_SD_STOP: assert property ($rose(DAC_SHUTDOWN) |-> SCL && SDA_IN)
    else $error("shutdown outside stop");
  AST_MODE_ACK: assert property (!$stable(SYNC_UPDATE_MODE) |-> SCL && !SDA_IN)
    else $error("sync mode moved outside ack");
  AST_START_QUIET: assert property (SCL && scl_q && sda_q && !SDA_IN |=> SDA_OE_N [*8])
    else $error("pull right after start");
endmodule // dsw_assertions

bind dsw_top dsw_assertions i_dsw_assertions (
  .REF_CLK(REF_CLK),
  .RESET(RESET),
  .SCL(SCL),
  .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT),
  .SDA_OE_N(SDA_OE_N),
  .DAC_CODE(DAC_CODE),
  .DAC_SHUTDOWN(DAC_SHUTDOWN),
  .INTERNAL_REF_SELECT(INTERNAL_REF_SELECT),
  .SYNC_UPDATE_MODE(SYNC_UPDATE_MODE)
);

// File: dsw_cond_det.sv
/*
  Edge and bus-condition detector on synchronised clock and data lines.
  Assumes both inputs already come through a synchroniser.
*/
`timescale 1ns/1ps
module dsw_cond_det (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_s,
  input wire logic sda_s,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);
  logic scl_q;
  logic sda_q;

  // Idle bus is high on both lines
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  // Data edges only count while the clock stays high
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s;
endmodule // dsw_cond_det

// File: dsw_map.svh
/*
  Constants for the DAC two-wire write slave: addresses, command fields,
  data layout and reset values. Included by the design files by bare name.
*/
`ifndef DSW_MAP_SVH
`define DSW_MAP_SVH

// Slave address parts
`define DSW_ADDR_HI_MAIN 4'h4
`define DSW_ADDR_HI_ALT 4'h3
`define DSW_FIXED_ADDR0 7'h20
`define DSW_FIXED_ADDR1 7'h21
`define DSW_FIXED_ADDR2 7'h22
`define DSW_SYNC_ADDR 7'h7E
`define DSW_RW_WRITE 1'h0
`define DSW_QUICK_UPDATE 1'h1

// Address byte field positions
`define DSW_ADDR_MSB 7
`define DSW_ADDR_LSB 1
`define DSW_RW_BIT 0

// Command byte field positions
`define DSW_CMD_SYNC_BIT 0
`define DSW_CMD_SHDN_BIT 1
`define DSW_CMD_IREF_BIT 2
`define DSW_CMD_MSB 2

// Data layout
`define DSW_BYTE_BITS 4'h8
`define DSW_CODE_HI_MSB 1
`define DSW_CODE_WIDTH 10

// Reset values
`define DSW_CMD_RST 3'h0
`define DSW_CODE_RST 10'h000
`define DSW_BYTE_RST 8'h00
`define DSW_BITCNT_RST 4'h0
`define DSW_FLAG_RST 1'h0

// Open-drain data line only ever pulls to this level
`define DSW_SDA_PULL 1'h0

`endif

// File: dsw_master.sv
/*
  Bus master model driving the two-wire clock and data lines.
  Assumes the wire level, pull-up and slave pull included, returns on sda_w.
*/
`timescale 1ns/1ps
module dsw_master (
  output logic scl,
  output logic sda,
  input wire logic sda_w
);
  realtime q = 31.25;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic start_c();
    // Offset keeps line edges off the clock edges
    #0.1 sda = 1'b1;
    #q scl = 1'b1;
    #q sda = 1'b0;
    #q scl = 1'b0;
    #q;
  endtask
  task automatic stop_c();
    sda = 1'b0;
    #q scl = 1'b1;
    #q sda = 1'b1;
    #q;
  endtask
  task automatic byte_w(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda = b[i];
      #q scl = 1'b1;
      #(2 * q) scl = 1'b0;
      #q;
    end
    sda = 1'b1;
    #q scl = 1'b1;
    #q ack = ~sda_w;
    #q scl = 1'b0;
    #q;
  endtask
  // Only the top n bits of a byte, to cut a byte short
  task automatic part_w(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      sda = b[i];
      #q scl = 1'b1;
      #(2 * q) scl = 1'b0;
      #q;
    end
  endtask
endmodule // dsw_master

// File: dsw_pkg.sv
/*
  Types for the DAC two-wire write slave: bus state and byte position.
  Assumes nothing of its surroundings.
*/
package dsw_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RECV = 4'b0010,
    ST_ACK  = 4'b0100,
    ST_SKIP = 4'b1000
  } dsw_state_e;

  typedef enum logic [4:0] {
    BY_ADDR  = 5'b00001,
    BY_CMD   = 5'b00010,
    BY_LO    = 5'b00100,
    BY_HI    = 5'b01000,
    BY_QUICK = 5'b10000
  } dsw_byte_e;

endpackage

// File: dsw_sync.sv
/*
  Two-flop synchroniser for a group of asynchronous levels.
  Assumes the inputs are quasi-static compared with the clock.
*/
`timescale 1ns/1ps
module dsw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_bad_w
    $error("dsw_sync: width must be at least 1");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // dsw_sync

// File: dsw_top.sv
/*
  Write-only two-wire slave of a 10-bit DAC: address match, acknowledge,
  command and data input registers, output registers and shutdown.
  Assumes a bus master on SCL/SDA with external pull-ups; SDA is split into
  input, output and active-low output enable. REF_CLK is far faster than SCL.
*/
`timescale 1ns/1ps
`include "dsw_map.svh"
module dsw_top import dsw_pkg::*; #(
  parameter bit PIN_ADDR_EN = 1'b1,
  parameter logic [3:0] ADDR_UPPER = `DSW_ADDR_HI_MAIN,
  parameter logic [6:0] FIXED_ADDR = `DSW_FIXED_ADDR0
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic ADDR_SEL_BIT0,
  input wire logic ADDR_SEL_BIT1,
  input wire logic ADDR_SEL_BIT2,
  output logic [`DSW_CODE_WIDTH-1:0] DAC_CODE,
  output logic DAC_SHUTDOWN,
  output logic INTERNAL_REF_SELECT,
  output logic SYNC_UPDATE_MODE
);

  if (ADDR_UPPER != `DSW_ADDR_HI_MAIN && ADDR_UPPER != `DSW_ADDR_HI_ALT) begin : g_bad_upper
    $error("dsw_top: ADDR_UPPER must be one of the two supported nibbles");
  end
  if (FIXED_ADDR != `DSW_FIXED_ADDR0 && FIXED_ADDR != `DSW_FIXED_ADDR1 &&
      FIXED_ADDR != `DSW_FIXED_ADDR2) begin : g_bad_fixed
    $error("dsw_top: FIXED_ADDR must be one of the three supported addresses");
  end
  if (`DSW_CODE_WIDTH != `DSW_CODE_HI_MSB + 1 + `DSW_BYTE_BITS) begin : g_bad_width
    $error("dsw_top: code width must match the two data bytes");
  end

  logic scl_s;
  logic sda_s;
  logic [2:0] addr_pins_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  dsw_state_e state_q;
  dsw_byte_e byte_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [`DSW_CMD_MSB:0] cmd_q;
  logic [7:0] lo_hold_q;
  logic [`DSW_CODE_WIDTH-1:0] in_code_q;
  logic [`DSW_CODE_WIDTH-1:0] out_code_q;
  logic ref_q;
  logic shdn_q;

  logic byte_done;
  logic ack_end;
  logic ack_rise;
  logic addr_is_slave;
  logic addr_is_sync;
  logic quick_update;
  logic quick_clear;
  logic stop_update;
  logic cmd_take;
  logic lo_take;
  logic hi_take;
  logic quick_take;

  // Link lines and address straps are asynchronous to REF_CLK
  dsw_sync #(
    .W(2),
    .RST_VAL(2'b11)
  ) u_sync_bus (
    .clk(REF_CLK),
    .rst(RESET),
    .d({SCL, SDA_IN}),
    .q({scl_s, sda_s})
  );

  dsw_sync #(
    .W(3),
    .RST_VAL(3'b000)
  ) u_sync_pins (
    .clk(REF_CLK),
    .rst(RESET),
    .d({ADDR_SEL_BIT2, ADDR_SEL_BIT1, ADDR_SEL_BIT0}),
    .q(addr_pins_s)
  );

  dsw_cond_det u_cond (
    .clk(REF_CLK),
    .rst(RESET),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // Own slave address for this build
  function automatic logic match_slave(input logic [6:0] a, input logic [2:0] pins);
    logic [6:0] own;
    own = PIN_ADDR_EN ? {ADDR_UPPER, pins} : FIXED_ADDR;
    match_slave = (a == own);
  endfunction

  // Acknowledge clock rise seen while the given byte is the current one
  function automatic logic ack_rise_of(input logic rise, input dsw_byte_e cur,
                                       input dsw_byte_e want);
    ack_rise_of = rise && (cur == want);
  endfunction

  assign addr_is_slave = match_slave(shift_q[`DSW_ADDR_MSB:`DSW_ADDR_LSB], addr_pins_s) &&
                         (shift_q[`DSW_RW_BIT] == `DSW_RW_WRITE);
  assign addr_is_sync = (shift_q[`DSW_ADDR_MSB:`DSW_ADDR_LSB] == `DSW_SYNC_ADDR);

  assign byte_done = (state_q == ST_RECV) && (bit_cnt_q == `DSW_BYTE_BITS) && scl_fall;
  assign ack_rise = (state_q == ST_ACK) && scl_rise;
  assign ack_end = (state_q == ST_ACK) && scl_fall;

  // Latching points of the input registers
  assign cmd_take = ack_rise_of(ack_rise, byte_q, BY_CMD);
  assign lo_take = ack_rise_of(ack_rise, byte_q, BY_LO);
  assign hi_take = ack_rise_of(ack_rise, byte_q, BY_HI);
  assign quick_take = ack_rise_of(ack_rise, byte_q, BY_QUICK);

  // Sync quick command acts on the acknowledge clock rise
  assign quick_update = quick_take && (shift_q[`DSW_RW_BIT] == `DSW_QUICK_UPDATE) &&
                        cmd_q[`DSW_CMD_SYNC_BIT];
  assign quick_clear = quick_take && (shift_q[`DSW_RW_BIT] != `DSW_QUICK_UPDATE);
  assign stop_update = stop_det && !cmd_q[`DSW_CMD_SYNC_BIT];

  // Bus state; START always restarts, STOP always ends
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= ST_IDLE;
    end else if (start_det) begin
      state_q <= ST_RECV;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_IDLE;
        end
        ST_RECV: begin
          if (byte_done) begin
            if (byte_q != BY_ADDR || addr_is_slave || addr_is_sync) begin
              state_q <= ST_ACK;
            end else begin
              state_q <= ST_SKIP;
            end
          end
        end
        ST_ACK: begin
          if (ack_end) begin
            if (byte_q == BY_HI || byte_q == BY_QUICK) begin
              state_q <= ST_SKIP;
            end else begin
              state_q <= ST_RECV;
            end
          end
        end
        ST_SKIP: begin
          state_q <= ST_SKIP;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Byte position within the transfer
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      byte_q <= BY_ADDR;
    end else if (start_det) begin
      byte_q <= BY_ADDR;
    end else if (byte_done && byte_q == BY_ADDR && !addr_is_slave && addr_is_sync) begin
      byte_q <= BY_QUICK;
    end else if (ack_end) begin
      case (byte_q)
        BY_ADDR: byte_q <= BY_CMD;
        BY_CMD: byte_q <= BY_LO;
        BY_LO: byte_q <= BY_HI;
        default: byte_q <= byte_q;
      endcase
    end
  end

  // Bit counter and receive shifter
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      bit_cnt_q <= `DSW_BITCNT_RST;
      shift_q <= `DSW_BYTE_RST;
    end else if (start_det || ack_end) begin
      bit_cnt_q <= `DSW_BITCNT_RST;
    end else if (state_q == ST_RECV && scl_rise && bit_cnt_q != `DSW_BYTE_BITS) begin
      shift_q <= {shift_q[6:0], sda_s};
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // Command input register, latched only on its own acknowledge
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      cmd_q <= `DSW_CMD_RST;
    end else if (quick_clear) begin
      cmd_q <= `DSW_CMD_RST;
    end else if (cmd_take) begin
      // Upper command bits are dropped here
      cmd_q <= shift_q[`DSW_CMD_MSB:0];
    end
  end

  // Data input registers; low byte held until high byte acknowledged
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      lo_hold_q <= `DSW_BYTE_RST;
    end else if (quick_clear) begin
      lo_hold_q <= `DSW_BYTE_RST;
    end else if (lo_take) begin
      lo_hold_q <= shift_q;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      in_code_q <= `DSW_CODE_RST;
    end else if (quick_clear) begin
      in_code_q <= `DSW_CODE_RST;
    end else if (hi_take) begin
      // Both bytes commit together, so a broken word leaves no trace
      in_code_q <= {shift_q[`DSW_CODE_HI_MSB:0], lo_hold_q};
    end
  end

  // Output registers: STOP in normal mode, sync acknowledge in sync mode
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      out_code_q <= `DSW_CODE_RST;
      ref_q <= `DSW_FLAG_RST;
    end else if (quick_clear) begin
      out_code_q <= `DSW_CODE_RST;
      ref_q <= `DSW_FLAG_RST;
    end else if (stop_update || quick_update) begin
      out_code_q <= in_code_q;
      ref_q <= cmd_q[`DSW_CMD_IREF_BIT];
    end
  end

  // Shutdown follows the command at STOP; a sync clear acknowledge resets it
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      shdn_q <= `DSW_FLAG_RST;
    end else if (quick_clear) begin
      shdn_q <= `DSW_FLAG_RST;
    end else if (stop_det) begin
      shdn_q <= cmd_q[`DSW_CMD_SHDN_BIT];
    end
  end

  // Open drain: only ever pulls low, and only in the acknowledge slot
  assign SDA_OUT = `DSW_SDA_PULL;
  assign SDA_OE_N = (state_q != ST_ACK);

  assign DAC_CODE = out_code_q;
  assign DAC_SHUTDOWN = shdn_q;
  assign INTERNAL_REF_SELECT = ref_q;
  assign SYNC_UPDATE_MODE = cmd_q[`DSW_CMD_SYNC_BIT];

endmodule // dsw_top

// File: dsw_top_tb_top.sv
/*
  Testbench of the DAC two-wire slave: master transfers and output checks.
  Assumes the master model and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "dsw_map.svh"
module dsw_top_tb_top;
  logic ref_clk, reset, scl, ms_sda, ack, oe_n, shdn, iref, syncm, sda_out;
  logic [2:0] sel;
  logic [`DSW_CODE_WIDTH-1:0] code;
  int bad_count = 0;
  int checks_done = 0;
  wire sda_w = ms_sda & (oe_n | sda_out);
  dsw_top i_dsw_top (
    .REF_CLK(ref_clk),
    .RESET(reset),
    .SCL(scl),
    .SDA_IN(sda_w),
    .SDA_OUT(sda_out),
    .SDA_OE_N(oe_n),
    .ADDR_SEL_BIT0(sel[0]),
    .ADDR_SEL_BIT1(sel[1]),
    .ADDR_SEL_BIT2(sel[2]),
    .DAC_CODE(code),
    .DAC_SHUTDOWN(shdn),
    .INTERNAL_REF_SELECT(iref),
    .SYNC_UPDATE_MODE(syncm)
  );
  dsw_master i_dsw_master (.scl(scl), .sda(ms_sda), .sda_w(sda_w));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic cmpf(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic cmpc(input logic [9:0] e);
    checks_done++;
    if (code !== e) begin
      bad_count++;
      $display("unexpected code: expected %h, seen %h", e, code);
    end
  endtask
  task automatic wr(input logic [7:0] bs[$], input int na);
    i_dsw_master.start_c();
    foreach (bs[i]) begin
      i_dsw_master.byte_w(bs[i], ack);
      cmpf("ack", logic'(i < na), ack);
    end
  endtask
  task automatic fin(input string t);
    i_dsw_master.stop_c();
    repeat (10) @(negedge ref_clk);
    if (t != "") $display("test %s done", t);
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    bad_count++;
    $display("unexpected run: expected end, seen timeout");
    summarize();
  end
  initial begin
    reset = 1'b1;
    sel = 3'h5;
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    cmpf("oe_n", 1'b1, oe_n);
    cmpc(10'h000);
    cmpf("shdn", 1'b0, shdn);
    cmpf("iref", 1'b0, iref);
    cmpf("syncm", 1'b0, syncm);
    wr('{8'h4A, 8'hFC, 8'hA5, 8'hFE}, 4);
    cmpc(10'h000);
    fin("word");
    cmpc(10'h2A5);
    cmpf("iref", 1'b1, iref);
    cmpf("shdn", 1'b0, shdn);
    wr('{8'h4C, 8'h00}, 0);
    fin("other address");
    wr('{8'h4B}, 0);
    fin("read refused");
    cmpf("iref", 1'b1, iref);
    wr('{8'h4A, 8'h00, 8'h11, 8'h03, 8'h55}, 4);
    fin("refuse");
    cmpc(10'h311);
    wr('{8'h4A, 8'h02}, 2);
    cmpf("shdn", 1'b0, shdn);
    fin("send byte");
    cmpf("shdn", 1'b1, shdn);
    cmpc(10'h311);
    wr('{8'h4A, 8'h00, 8'h77}, 3);
    wr('{8'h4C}, 0);
    fin("abort");
    cmpf("shdn", 1'b0, shdn);
    cmpc(10'h311);
    wr('{8'h4A, 8'h07, 8'h33, 8'h01}, 4);
    fin("sync word");
    cmpf("syncm", 1'b1, syncm);
    cmpf("shdn", 1'b1, shdn);
    cmpf("iref", 1'b0, iref);
    cmpc(10'h311);
    wr('{8'hFD}, 1);
    cmpc(10'h133);
    cmpf("iref", 1'b1, iref);
    fin("sync update");
    wr('{8'hFC}, 1);
    cmpf("shdn", 1'b0, shdn);
    fin("sync clear");
    cmpc(10'h000);
    cmpf("syncm", 1'b0, syncm);
    cmpf("iref", 1'b0, iref);
    wr('{8'h4A}, 1);
    i_dsw_master.part_w(8'hFF, 7);
    fin("partial");
    cmpf("syncm", 1'b0, syncm);
    cmpf("shdn", 1'b0, shdn);
    summarize();
  end
endmodule // dsw_top_tb_top
